// ===== hw/bmi_board_ctl.sv
// Purpose: Decodes the configuration switch bank, handles the push button and
//   drives the nine status indicators of the capture board.
// Assumes: pushButton is high while pressed; a switch bit is high when ON.
//   Inputs named as pins are asynchronous; the rest come from logic on clk.
// Notes: Operation
// Operation
// (R1) Button in reset mode: target reset low and internal reset while pressed.
// (R2) Button in reinit mode: each press resends stored initial settings.
// (R3) Host configuration bit selects reset or reinit function of the button.
// (R4) Monitor mode: position one off gives 60 fps, on gives 30 fps.
// (R5) Positions four and three pick lane count: 4, 1, 2 or 3 lanes.
// (R6) Monitor mode: positions five, six pick 1080p, 720p, 4k30, custom/1440p.
// (R7) Positions seven, eight sampled once at power-on choose the working mode.
// (R8) Configured timing data overrides resolution and frame-rate switches.
// (R9) Custom setting uses timing data if present, else 1440p.
// (R10) Pixel format is YUV by default, RGB when configured.
// (R11) Position two off gives normal video, on gives colour test pattern.
// (R12) All indicators flash rapidly until startup completes, then show meanings.
// (R13) Indicator one lit while target connector power is valid.
// (R14) Indicator two lit while the clock to the target is locked.
// (R15) Indicator three lit while frame syncs arrive from the target.
// (R16) Indicator four toggles every third target vertical sync.
// (R17) USB camera mode: indicator eight lit while the host captures.
// (R18) Monitor mode: indicator nine toggles every third monitor vertical sync.
// (R19) USB camera mode: indicator nine toggles every third USB vertical sync.
// (R20) Target reset output is active low.
// (R21) Button and switches are synchronised and debounced before use.
`timescale 1ns/1ps

module bmi_board_ctl #(
  parameter int DEBOUNCE_LEN = bmi_pkg::DEBOUNCE_CYCLES,
  parameter int FLASH_LEN = bmi_pkg::FLASH_HALF_CYCLES,
  parameter int SYNC_TIMEOUT_LEN = bmi_pkg::SYNC_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic pushButton,
  input wire logic [7:0] configSwitchBank,
  input wire logic targetPowerGood,
  input wire logic clockLocked,
  input wire logic targetVsync,
  input wire logic buttonReinitSel,
  input wire logic timingDataValid,
  input wire logic rgbSelect,
  input wire logic startupDone,
  input wire logic monitorVsync,
  input wire logic usbVsync,
  input wire logic captureActive,
  output logic targetResetN,
  output logic logicReset,
  output logic reinitPulse,
  output logic modeValid,
  output bmi_pkg::bmi_mode_e workingMode,
  output logic frameRate30,
  output logic testPattern,
  output logic [2:0] laneCount,
  output bmi_pkg::bmi_res_e resolution,
  output logic pixelRgb,
  output logic [8:0] indicators
);
  import bmi_pkg::*;

  // Counter limits at counter width; the defaults all fit in CNT_W bits.
  localparam logic [CNT_W-1:0] DEB_LAST = CNT_W'(DEBOUNCE_LEN - 1);
  localparam logic [CNT_W-1:0] FLASH_LAST = CNT_W'(FLASH_LEN - 1);
  localparam logic [CNT_W-1:0] SYNC_LAST = CNT_W'(SYNC_TIMEOUT_LEN - 1);

  bmi_state_s q;
  bmi_state_s d;

  // Next-state logic for the whole block.
  always_comb begin
    logic pressEdge;
    logic vsEdge;
    logic monEdge;
    logic usbEdge;
    logic [1:0] resSel;
    pressEdge = 1'b0;
    vsEdge = 1'b0;
    monEdge = 1'b0;
    usbEdge = 1'b0;
    resSel = 2'h0;
    d = q;

    // Two-stage synchronisers; only the second stage feeds any logic.
    d.btnS1 = pushButton; // see (R21)
    d.btnS2 = q.btnS1;
    d.swS1 = configSwitchBank; // see (R21)
    d.swS2 = q.swS1;
    d.pwrS1 = targetPowerGood;
    d.pwrS2 = q.pwrS1;
    d.lockS1 = clockLocked;
    d.lockS2 = q.lockS1;
    d.vsS1 = targetVsync;
    d.vsS2 = q.vsS1;
    d.vsPrev = q.vsS2;

    // Button debounce: a new level must hold for the whole settling time.
    if (q.btnS2 != q.btnCand) begin
      d.btnCand = q.btnS2; // see (R21)
      d.btnCnt = '0;
    end else if (q.btnCnt == DEB_LAST) begin
      d.btnDeb = q.btnCand; // see (R21)
    end else begin
      d.btnCnt = q.btnCnt + CNT_W'(1);
    end

    // Switch debounce treats the bank as one word, so a half-moved bank never
    // decodes into a mix of old and new settings.
    if (q.swS2 != q.swCand) begin
      d.swCand = q.swS2; // see (R21)
      d.swCnt = '0;
    end else if (q.swCnt == DEB_LAST) begin
      d.swDeb = q.swCand; // see (R21)
      d.swSettled = 1'b1;
    end else begin
      d.swCnt = q.swCnt + CNT_W'(1);
    end

    // The working mode is taken once, from the first settled switch word after
    // reset; later moves of positions seven and eight have no effect.
    if (q.swSettled && !q.modeTaken) begin
      d.modeTaken = 1'b1; // see (R7)
      case ({q.swDeb[SW_MODE_8], q.swDeb[SW_MODE_7]})
        2'h0: d.mode = MODE_MONITOR; // see (R7)
        2'h1: d.mode = MODE_UPDATER;
        2'h2: d.mode = MODE_USB_CAMERA;
        default: d.mode = MODE_RESERVED;
      endcase
    end

    // Button action, chosen by the host setting.
    pressEdge = (q.btnCnt == DEB_LAST) && (q.btnS2 == q.btnCand) && q.btnCand && !q.btnDeb;
    if (!buttonReinitSel) begin
      // Reset follows the debounced button level for as long as it is held.
      d.targetResetN = !q.btnDeb; // see (R1) (R3) (R20)
      d.logicReset = q.btnDeb; // see (R1)
      d.reinitPulse = 1'b0;
    end else begin
      // One resend per press; holding the button does not repeat it.
      d.targetResetN = 1'b1; // see (R3) (R20)
      d.logicReset = 1'b0;
      d.reinitPulse = pressEdge; // see (R2) (R3)
    end

    // Lane count and test pattern apply in every mode.
    case ({q.swDeb[SW_LANE_HI], q.swDeb[SW_LANE_LO]})
      2'h0: d.laneCount = 3'h4; // see (R5)
      2'h1: d.laneCount = 3'h1;
      2'h2: d.laneCount = 3'h2;
      default: d.laneCount = 3'h3;
    endcase
    d.testPattern = q.swDeb[SW_TEST_PATTERN]; // see (R11)
    d.pixelRgb = rgbSelect; // see (R10)

    // Output format. Outside monitor mode the switches hold no meaning for it
    // and the outputs rest at 1080p, 60 fps.
    resSel = {q.swDeb[SW_RES_5], q.swDeb[SW_RES_6]};
    if (q.mode != MODE_MONITOR) begin
      d.resolution = RES_1080P;
      d.frameRate30 = 1'b0;
    end else if (timingDataValid) begin
      d.resolution = RES_TIMING_DATA; // see (R8) (R9)
      d.frameRate30 = 1'b0; // see (R8)
    end else begin
      case (resSel)
        2'h0: d.resolution = RES_1080P; // see (R6)
        2'h1: d.resolution = RES_720P;
        2'h2: d.resolution = RES_2160P30;
        default: d.resolution = RES_1440P; // see (R9)
      endcase
      // The 4k setting runs at 30 fps only, whatever position one says.
      d.frameRate30 = q.swDeb[SW_FRAME_RATE] || (resSel == 2'h2); // see (R4) (R6)
    end

    // Target frame sync: presence watchdog and divide-by-three blink.
    vsEdge = q.vsS2 && !q.vsPrev;
    if (vsEdge) begin
      d.syncCnt = '0; // see (R15)
      d.syncSeen = 1'b1;
      if (q.inDiv == BLINK_DIV_LAST) begin
        d.inDiv = 2'h0; // see (R16)
        d.inBlink = !q.inBlink;
      end else begin
        d.inDiv = q.inDiv + 2'h1;
      end
    end else if (q.syncCnt == SYNC_LAST) begin
      d.syncSeen = 1'b0; // see (R15)
    end else begin
      d.syncCnt = q.syncCnt + CNT_W'(1);
    end

    // Output frame sync for indicator nine: monitor sync in monitor mode,
    // USB video sync in camera mode.
    d.monPrev = monitorVsync;
    d.usbPrev = usbVsync;
    monEdge = monitorVsync && !q.monPrev;
    usbEdge = usbVsync && !q.usbPrev;
    if ((q.mode == MODE_MONITOR && monEdge) || (q.mode == MODE_USB_CAMERA && usbEdge)) begin
      if (q.outDiv == BLINK_DIV_LAST) begin
        d.outDiv = 2'h0; // see (R18) (R19)
        d.outBlink = !q.outBlink;
      end else begin
        d.outDiv = q.outDiv + 2'h1;
      end
    end

    // Rapid flash source for the startup period.
    if (q.flashCnt == FLASH_LAST) begin
      d.flashCnt = '0;
      d.flash = !q.flash;
    end else begin
      d.flashCnt = q.flashCnt + CNT_W'(1);
    end

    // Indicator map; bit n drives indicator n+1. Indicators five to seven
    // have no assigned meaning and stay dark after startup.
    if (!startupDone) begin
      d.indicators = {9{q.flash}}; // see (R12)
    end else begin
      d.indicators = 9'h000; // see (R12)
      d.indicators[0] = q.pwrS2; // see (R13)
      d.indicators[1] = q.lockS2; // see (R14)
      d.indicators[2] = q.syncSeen; // see (R15)
      d.indicators[3] = q.inBlink; // see (R16)
      d.indicators[7] = (q.mode == MODE_USB_CAMERA) && captureActive; // see (R17)
      d.indicators[8] = (q.mode == MODE_MONITOR || q.mode == MODE_USB_CAMERA) && q.outBlink; // see (R18) (R19)
    end
  end

  // State register. The internal reset output does not reset this block, so
  // the button keeps being watched while it holds the rest of the design.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= STATE_RESET;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state register.
  assign targetResetN = q.targetResetN;
  assign logicReset = q.logicReset;
  assign reinitPulse = q.reinitPulse;
  assign modeValid = q.modeTaken;
  assign workingMode = q.mode;
  assign frameRate30 = q.frameRate30;
  assign testPattern = q.testPattern;
  assign laneCount = q.laneCount;
  assign resolution = q.resolution;
  assign pixelRgb = q.pixelRgb;
  assign indicators = q.indicators;

endmodule : bmi_board_ctl

// ===== hw/bmi_pkg.sv
// Purpose: Shared types and constants for the board mode and indicator logic.
// Assumes: A single 200 MHz system clock; switch inputs read 1 when a position is ON.
// Notes: Times are given in milliseconds and are turned into cycle counts here.
package bmi_pkg;

  // Clock rate in kHz. Keeping it in kHz keeps the cycle products below 2**31.
  localparam int CLK_KHZ = 200_000;

  // Settling time that a switch or button must hold before it is believed.
  localparam int DEBOUNCE_MS = 10;
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_MS * CLK_KHZ;

  // Half period of the rapid flash shown while startup is still running.
  localparam int FLASH_HALF_MS = 50;
  localparam int FLASH_HALF_CYCLES = FLASH_HALF_MS * CLK_KHZ;

  // Absence of target frame syncs for this long clears the sync-present indicator.
  localparam int SYNC_TIMEOUT_MS = 100;
  localparam int SYNC_TIMEOUT_CYCLES = SYNC_TIMEOUT_MS * CLK_KHZ;

  // Width of every long counter; 2**25 covers the largest count above.
  localparam int CNT_W = 25;

  // Switch bank positions, position one sitting in bit zero.
  localparam int SW_FRAME_RATE = 0;
  localparam int SW_TEST_PATTERN = 1;
  localparam int SW_LANE_LO = 2;
  localparam int SW_LANE_HI = 3;
  localparam int SW_RES_5 = 4;
  localparam int SW_RES_6 = 5;
  localparam int SW_MODE_7 = 6;
  localparam int SW_MODE_8 = 7;

  // Last divider count, so three frame sync edges per toggle of the blinking indicators.
  localparam logic [1:0] BLINK_DIV_LAST = 2'h2;

  // Working mode chosen at power-on.
  typedef enum logic [1:0] {
    MODE_MONITOR,
    MODE_USB_CAMERA,
    MODE_UPDATER,
    MODE_RESERVED
  } bmi_mode_e;

  // Monitor output format handed to the output pipeline.
  typedef enum logic [2:0] {
    RES_1080P,
    RES_720P,
    RES_2160P30,
    RES_1440P,
    RES_TIMING_DATA
  } bmi_res_e;

  // All state of the top module.
  typedef struct packed {
    logic btnS1;
    logic btnS2;
    logic [7:0] swS1;
    logic [7:0] swS2;
    logic pwrS1;
    logic pwrS2;
    logic lockS1;
    logic lockS2;
    logic vsS1;
    logic vsS2;
    logic vsPrev;
    logic btnCand;
    logic btnDeb;
    logic [CNT_W-1:0] btnCnt;
    logic [7:0] swCand;
    logic [7:0] swDeb;
    logic [CNT_W-1:0] swCnt;
    logic swSettled;
    logic modeTaken;
    bmi_mode_e mode;
    logic [CNT_W-1:0] syncCnt;
    logic syncSeen;
    logic [1:0] inDiv;
    logic inBlink;
    logic monPrev;
    logic usbPrev;
    logic [1:0] outDiv;
    logic outBlink;
    logic [CNT_W-1:0] flashCnt;
    logic flash;
    logic targetResetN;
    logic logicReset;
    logic reinitPulse;
    logic frameRate30;
    logic testPattern;
    logic [2:0] laneCount;
    bmi_res_e resolution;
    logic pixelRgb;
    logic [8:0] indicators;
  } bmi_state_s;

  // Value of the state after reset; the target is held in reset until released.
  localparam bmi_state_s STATE_RESET = '{
    mode: MODE_MONITOR,
    resolution: RES_1080P,
    laneCount: 3'h4,
    logicReset: 1'b1,
    default: '0
  };

endpackage : bmi_pkg

// ===== tb/bmi_board_ctl_properties.sv
// Purpose: Port-level checks of the board mode and indicator logic.
// Assumes: Bound to every instance of the top module.
// Notes: Only relations visible at the ports are watched.
`timescale 1ns/1ps
module bmi_board_ctl_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic startupDone,
  input wire logic timingDataValid,
  input wire logic targetResetN,
  input wire logic logicReset,
  input wire logic reinitPulse,
  input wire logic modeValid,
  input wire bmi_pkg::bmi_mode_e workingMode,
  input wire logic frameRate30,
  input wire bmi_pkg::bmi_res_e resolution,
  input wire logic [8:0] indicators
);
  import bmi_pkg::*;
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Two calm cycles are needed before the lamps are judged.
  sequence booting; !startupDone ##1 !startupDone; endsequence
  sequence running; startupDone ##1 startupDone; endsequence
  sequence timed; modeValid && workingMode == MODE_MONITOR && timingDataValid; endsequence
  reset_pair_a: assert property (logicReset == !targetResetN)
    else $error("Target and internal reset disagree.");
  reinit_single_a: assert property (reinitPulse |=> !reinitPulse)
    else $error("Reinit request longer than one cycle.");
  reinit_quiet_a: assert property (reinitPulse |-> targetResetN)
    else $error("Reinit press also reset the target.");
  timing_wins_a: assert property (
    timed |=> resolution == RES_TIMING_DATA && !frameRate30)
    else $error("Timing data did not take precedence.");
  four_k_a: assert property (resolution == RES_2160P30 |-> frameRate30)
    else $error("Four k format not at 30 fps.");
  mode_locked_a: assert property (
    modeValid |=> modeValid && $stable(workingMode))
    else $error("Working mode changed after power-on.");
  startup_flash_a: assert property (
    booting |-> indicators == 9'h000 || indicators == 9'h1FF)
    else $error("Lamps not flashing together in startup.");
  unused_dark_a: assert property (running |-> indicators[6:4] == 3'h0)
    else $error("Unassigned lamps lit.");
  capture_mode_a: assert property (
    (workingMode != MODE_USB_CAMERA) throughout running |-> !indicators[7])
    else $error("Capture lamp lit outside camera mode.");
endmodule : bmi_board_ctl_properties

bind bmi_board_ctl bmi_board_ctl_properties bmi_board_ctl_properties_i (.clk, .sys_rst,
  .startupDone, .timingDataValid, .targetResetN, .logicReset, .reinitPulse, .modeValid,
  .workingMode, .frameRate30, .resolution, .indicators);

// ===== tb/bmi_target_model.sv
// Purpose: Target board model that sends frame syncs to the capture logic.
// Assumes: runSync is driven by the bench on the rising edge.
// Notes: A sync lasts one cycle and repeats every sixteen cycles.
`timescale 1ns/1ps
module bmi_target_model (
  input wire logic clk,
  input wire logic targetResetN,
  input wire logic runSync,
  output logic targetVsync
);
  logic [3:0] phase_q;
  // A target held in reset is silent, so syncs need the reset released.
  always_ff @(posedge clk) begin
    if (!runSync || !targetResetN) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end
  assign targetVsync = runSync && targetResetN && (phase_q == 4'hF);
endmodule : bmi_target_model

// ===== tb/test_bmi_board_ctl.sv
// Purpose: Self-checking bench for the board mode and indicator logic.
// Assumes: Counts are shortened so the run stays brief.
// Notes: All three working modes under test are entered through a fresh reset.
`timescale 1ns/1ps
module test_bmi_board_ctl;
  import bmi_pkg::*;
  localparam int SETTLE = 20;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic pushButton = 1'b0;
  logic [7:0] configSwitchBank = 8'h00;
  logic targetPowerGood = 1'b0;
  logic clockLocked = 1'b0;
  logic buttonReinitSel = 1'b0;
  logic timingDataValid = 1'b0;
  logic rgbSelect = 1'b0;
  logic startupDone = 1'b0;
  logic monitorVsync = 1'b0;
  logic usbVsync = 1'b0;
  logic captureActive = 1'b0;
  logic runSync = 1'b0;
  logic targetVsync, targetResetN, logicReset, reinitPulse, modeValid;
  logic frameRate30, testPattern, pixelRgb;
  logic [2:0] laneCount;
  logic [8:0] indicators;
  bmi_mode_e workingMode;
  bmi_res_e resolution;
  int errors = 0;
  int num_checks = 0;
  int pulses = 0;
  int base = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  bmi_board_ctl #(.DEBOUNCE_LEN(8), .FLASH_LEN(16), .SYNC_TIMEOUT_LEN(64)) bmi_board_ctl_i (
    .clk, .sys_rst, .pushButton, .configSwitchBank, .targetPowerGood, .clockLocked,
    .targetVsync, .buttonReinitSel, .timingDataValid, .rgbSelect, .startupDone, .monitorVsync,
    .usbVsync, .captureActive, .targetResetN, .logicReset, .reinitPulse, .modeValid,
    .workingMode, .frameRate30, .testPattern, .laneCount, .resolution, .pixelRgb, .indicators);
  bmi_target_model bmi_target_model_i (.clk, .targetResetN, .runSync, .targetVsync);
  task automatic end_sim();
    if (errors == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  // Counts reinit requests and cuts a hung run short.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (reinitPulse === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (cycles == 3000) begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  // Switches only count once the debounce has run out, hence the long wait.
  task automatic setSw(input logic [7:0] v);
    configSwitchBank <= v;
    tick(SETTLE);
  endtask : setSw
  task automatic pulseV(input logic usb, input int n);
    repeat (n) begin
      @(posedge clk);
      monitorVsync <= !usb;
      usbVsync <= usb;
      @(posedge clk);
      monitorVsync <= 1'b0;
      usbVsync <= 1'b0;
      tick(2);
    end
  endtask : pulseV
  task automatic doReset(input logic [7:0] v);
    configSwitchBank <= v;
    startupDone <= 1'b0;
    sys_rst <= 1'b1;
    tick(4);
    sys_rst <= 1'b0;
    tick(8);
    chk("flash dark", 9'h000, indicators);
    tick(16);
    chk("flash lit", 9'h1FF, indicators);
    tick(SETTLE);
    chk("mode valid", 9'h1, 9'(modeValid));
  endtask : doReset
  initial begin
    doReset(8'h00);
    chk("monitor mode", 9'(MODE_MONITOR), 9'(workingMode));
    chk("yuv", 9'h0, 9'(pixelRgb));
    chk("released", 9'h1, 9'(targetResetN));
    for (int i = 0; i < 4; i++) begin
      setSw({4'h0, 2'(i), 2'(i)});
      chk("lanes", (i == 0) ? 9'h4 : 9'(i), 9'(laneCount));
      chk("rate", 9'(i % 2), 9'(frameRate30));
      chk("pattern", 9'(i / 2), 9'(testPattern));
    end
    configSwitchBank <= 8'h00;
    tick(4);
    setSw(8'h0F);
    chk("glitch", 9'h3, 9'(laneCount));
    for (int i = 0; i < 4; i++) begin
      setSw({2'h0, i[0], i[1], 4'h0});
      chk("resolution", 9'(i), 9'(resolution));
      chk("4k rate", 9'(i == 2), 9'(frameRate30));
    end
    setSw(8'hF1);
    chk("mode kept", 9'(MODE_MONITOR), 9'(workingMode));
    chk("custom", 9'(RES_1440P), 9'(resolution));
    timingDataValid <= 1'b1;
    rgbSelect <= 1'b1;
    tick(3);
    chk("timing", 9'(RES_TIMING_DATA), 9'(resolution));
    chk("timing rate", 9'h0, 9'(frameRate30));
    chk("rgb", 9'h1, 9'(pixelRgb));
    pushButton <= 1'b1;
    tick(SETTLE);
    chk("target held", 9'h0, 9'(targetResetN));
    chk("logic held", 9'h1, 9'(logicReset));
    pushButton <= 1'b0;
    tick(SETTLE);
    chk("target free", 9'h1, 9'(targetResetN));
    chk("logic free", 9'h0, 9'(logicReset));
    buttonReinitSel <= 1'b1;
    base = pulses;
    pushButton <= 1'b1;
    tick(3 * SETTLE);
    chk("reinit count", 9'h1, 9'(pulses - base));
    chk("no reset", 9'h1, 9'(targetResetN));
    pushButton <= 1'b0;
    targetPowerGood <= 1'b1;
    startupDone <= 1'b1;
    tick(SETTLE);
    chk("power lamp", 9'h1, indicators & 9'h003);
    targetPowerGood <= 1'b0;
    clockLocked <= 1'b1;
    tick(5);
    chk("lock lamp", 9'h2, indicators & 9'h003);
    runSync <= 1'b1;
    tick(25);
    chk("in blink 1", 9'h0, 9'(indicators[3]));
    tick(25);
    runSync <= 1'b0;
    tick(5);
    chk("in blink 3", 9'h1, 9'(indicators[3]));
    chk("sync lamp", 9'h1, 9'(indicators[2]));
    tick(80);
    chk("sync lost", 9'h0, 9'(indicators[2]));
    pulseV(1'b0, 2);
    chk("out blink 2", 9'h0, 9'(indicators[8]));
    pulseV(1'b0, 1);
    tick(2);
    chk("out blink 3", 9'h1, 9'(indicators[8]));
    doReset(8'h80);
    chk("camera mode", 9'(MODE_USB_CAMERA), 9'(workingMode));
    chk("camera format", 9'(RES_1080P), 9'(resolution));
    startupDone <= 1'b1;
    captureActive <= 1'b1;
    tick(3);
    chk("capture lamp", 9'h1, 9'(indicators[7]));
    pulseV(1'b1, 3);
    tick(2);
    chk("usb blink", 9'h1, 9'(indicators[8]));
    // Updater mode: neither sync source may move indicator nine.
    doReset(8'h40);
    chk("updater mode", 9'(MODE_UPDATER), 9'(workingMode));
    startupDone <= 1'b1;
    pulseV(1'b0, 3);
    pulseV(1'b1, 3);
    tick(2);
    chk("updater blink", 9'h0, 9'(indicators[8]));
    chk("updater capture", 9'h0, 9'(indicators[7]));
    end_sim();
  end
endmodule : test_bmi_board_ctl
